// ### include/flash_ctrl_defs.vh
// Purpose: Shared constants for the flash program and erase control block.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes:   Offsets are register indices on the local port.
`ifndef FLASH_CTRL_DEFS_VH
`define FLASH_CTRL_DEFS_VH

`define ADDR_WIDTH           4
`define OFS_MODE_CONTROL     4'h0
`define OFS_LARGE_BLOCK_SEL  4'h2
`define OFS_BLOCK_STATUS     4'h4

`define BIT_VOLTAGE_DETECT   7
`define BIT_HIGH_VOLT_EN     6
`define BIT_ERASE_VERIFY     3
`define BIT_PROGRAM_VERIFY   2
`define BIT_ERASE            1
`define BIT_PROGRAM          0

`define MODE_WRITABLE_MASK   8'h4F
`define RESET_CLEAR          8'h00
`define RESET_WITH_VPP       8'h80
`define READ_DISABLED        8'hFF

`define CLK_FREQ_HZ          20000000
`define SUPPLY_SETTLE_US     5
`define SETTLE_CYCLES        ((`SUPPLY_SETTLE_US * `CLK_FREQ_HZ + 999999) / 1000000)

`define LARGE_BLOCK_KB       16
`define LAST_BLOCK_KB        12
`define LARGE_BLOCK_COUNT    8

`endif

// ### hdl/pin_sync.v
// Purpose: Two-stage synchroniser for asynchronous level inputs.
// Assumes: Inputs are slow levels; one clock domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
module pin_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             ref_clk_in,
  input  wire             reset_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ### hdl/block_range_decode.v
// Purpose: Map a flash address to its large block and qualify it.
// Assumes: Byte addresses with block 0 at the lowest address.
// Notes:   Seven 16 KB blocks then one 12 KB block; beyond is no large block.
`timescale 1ns/1ns
`include "flash_ctrl_defs.vh"
module block_range_decode
(
  input  wire [16:0] flash_addr_in,
  input  wire [7:0]  block_select_in,
  output wire        in_large_area_out,
  output wire        block_selected_out
);
  wire [2:0] block_index;
  wire       in_area;

  // Block index is the top three address bits because blocks are 16 KB aligned.
  assign block_index = flash_addr_in[16:14];
  // see R18
  assign in_area = (block_index != 3'h7) ||
                   (flash_addr_in[13:10] < 4'hC);
  assign in_large_area_out  = in_area;
  // see R17
  assign block_selected_out = in_area & block_select_in[block_index];
endmodule

// ### hdl/flash_program_erase_control.v
// Purpose: Mode control and large-block select for the on-chip flash.
// Assumes: Operating mode, standby and supply level arrive as async pins.
// Notes:   Registers hold byte data in the low bits of the read port.
// Notes on behaviour
// R1 - Mode control clears on reset, standby, no 12 V.
// R2 - With 12 V present reset value is 0x80.
// R3 - Modes 1-4: writes ignored, reads return 0xFF.
// R4 - Bit 7 reads programming voltage above threshold.
// R5 - Flag low protects flash against program, erase.
// R6 - Software waits 5 us after enabling high voltage.
// R7 - Software waits read setup after disabling high voltage.
// R8 - Never fetch enable-bit toggle instruction from flash.
// R9 - Bits 5 and 4 always read zero.
// R10 - Bit 3 enters or leaves erase-verify mode.
// R11 - Bit 2 enters or leaves program-verify mode.
// R12 - Bit 1 enters or leaves erase mode.
// R13 - Bit 0 enters or leaves program mode.
// R14 - Software sets one mode bit at most.
// R15 - Software arms watchdog before program or erase.
// R16 - Block select clears on reset, standby, supply loss, disable.
// R17 - Select bit n enables large block n.
// R18 - Eight blocks: seven 16 KB, last 12 KB.
`timescale 1ns/1ns
`include "flash_ctrl_defs.vh"
module flash_program_erase_control
#(
  parameter SETTLE_CYCLES = `SETTLE_CYCLES
)
(
  input  wire        ref_clk_in,
  input  wire        reset_in,
  input  wire [2:0]  op_mode_in,
  input  wire        standby_in,
  input  wire        high_voltage_threshold_in,
  input  wire [`ADDR_WIDTH-1:0] addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        write_in,
  input  wire        read_in,
  input  wire [16:0] flash_addr_in,
  output reg  [7:0]  rdata_out,
  output reg         program_mode_out,
  output reg         erase_mode_out,
  output reg         program_verify_mode_out,
  output reg         erase_verify_mode_out,
  output reg         high_voltage_enable_out,
  output reg         write_permit_out,
  output reg         supply_settled_out,
  output reg         block_selected_out
);
  wire [4:0] pins_sync;
  wire [2:0] op_mode;
  wire       standby;
  wire       voltage_present;
  wire       in_large_area;
  wire       addr_block_selected;

  reg  [7:0] mode_control;
  reg  [7:0] large_block_select;
  reg  [7:0] next_mode_control;
  reg  [7:0] next_large_block_select;
  reg  [7:0] next_rdata;
  reg  [12:0] settle_count;
  reg        settled;

  pin_sync
  #(
    .WIDTH (5)
  )
  u_pin_sync
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   ({op_mode_in, standby_in, high_voltage_threshold_in}),
    .sync_out   (pins_sync)
  );

  assign op_mode         = pins_sync[4:2];
  assign standby         = pins_sync[1];
  assign voltage_present = pins_sync[0];

  block_range_decode u_block_range_decode
  (
    .flash_addr_in      (flash_addr_in),
    .block_select_in    (large_block_select),
    .in_large_area_out  (in_large_area),
    .block_selected_out (addr_block_selected)
  );

  // Flash registers exist only while the on-chip flash is mapped in.
  function flash_enabled;
    input [2:0] mode;
    begin
      flash_enabled = (mode >= 3'h5);
    end
  endfunction

  function [7:0] mode_view;
    input [7:0] stored;
    input       vpp;
    begin
      // see R4
      // see R9
      mode_view = (stored & `MODE_WRITABLE_MASK) | {vpp, 7'h00};
    end
  endfunction

  always @*
  begin
    next_mode_control       = mode_control;
    next_large_block_select = large_block_select;
    next_rdata              = 8'h00;
    // see R10
    // see R11
    // see R12
    // see R13
    if (write_in && flash_enabled(op_mode) && (addr_in == `OFS_MODE_CONTROL))
    begin
      next_mode_control = wdata_in & `MODE_WRITABLE_MASK;
    end
    if (write_in && flash_enabled(op_mode) && (addr_in == `OFS_LARGE_BLOCK_SEL))
    begin
      // see R17
      next_large_block_select = wdata_in;
    end
    // see R1
    if (standby || !voltage_present || !flash_enabled(op_mode))
    begin
      next_mode_control = `RESET_CLEAR;
    end
    // see R16
    if (standby || !voltage_present || !next_mode_control[`BIT_HIGH_VOLT_EN] ||
        !flash_enabled(op_mode))
    begin
      next_large_block_select = `RESET_CLEAR;
    end
    if (read_in)
    begin
      if (!flash_enabled(op_mode) &&
          ((addr_in == `OFS_MODE_CONTROL) || (addr_in == `OFS_LARGE_BLOCK_SEL)))
      begin
        // see R3
        next_rdata = `READ_DISABLED;
      end
      else
      begin
        case (addr_in)
          `OFS_MODE_CONTROL:
          begin
            // see R2
            next_rdata = mode_view(mode_control, voltage_present);
          end
          `OFS_LARGE_BLOCK_SEL:
          begin
            next_rdata = large_block_select;
          end
          `OFS_BLOCK_STATUS:
          begin
            next_rdata = {5'h00, in_large_area, addr_block_selected, settled};
          end
          default:
          begin
            next_rdata = 8'h00;
          end
        endcase
      end
    end
  end

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      mode_control       <= `RESET_CLEAR;
      large_block_select <= `RESET_CLEAR;
      rdata_out          <= 8'h00;
    end
    else
    begin
      mode_control       <= next_mode_control;
      large_block_select <= next_large_block_select;
      rdata_out          <= next_rdata;
    end
  end

  // The settle counter only reports readiness; software still owns the wait.
  always @(posedge ref_clk_in)
  begin
    if (reset_in || !mode_control[`BIT_HIGH_VOLT_EN])
    begin
      settle_count <= 13'h0000;
      settled      <= 1'b0;
    end
    else if (settle_count >= SETTLE_CYCLES[12:0] - 13'h0001)
    begin
      // see R6
      settled <= 1'b1;
    end
    else
    begin
      settle_count <= settle_count + 13'h0001;
    end
  end

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      program_mode_out        <= 1'b0;
      erase_mode_out          <= 1'b0;
      program_verify_mode_out <= 1'b0;
      erase_verify_mode_out   <= 1'b0;
      high_voltage_enable_out <= 1'b0;
      write_permit_out        <= 1'b0;
      supply_settled_out      <= 1'b0;
      block_selected_out      <= 1'b0;
    end
    else
    begin
      // see R13
      program_mode_out        <= mode_control[`BIT_PROGRAM] & voltage_present;
      // see R12
      erase_mode_out          <= mode_control[`BIT_ERASE] & voltage_present;
      // see R11
      program_verify_mode_out <= mode_control[`BIT_PROGRAM_VERIFY];
      // see R10
      erase_verify_mode_out   <= mode_control[`BIT_ERASE_VERIFY];
      high_voltage_enable_out <= mode_control[`BIT_HIGH_VOLT_EN];
      // see R5
      write_permit_out        <= voltage_present & flash_enabled(op_mode);
      supply_settled_out      <= settled;
      // see R17
      block_selected_out      <= addr_block_selected & voltage_present;
    end
  end
endmodule

// ### tb/flash_ctrl_assertions.sv
// Purpose: Port assertions for the flash mode control block.
// Assumes: Pin effects land within six clocks.
// Notes: Pin checks wait until the pins have held steady.
`timescale 1ns/1ns
`include "flash_ctrl_defs.vh"
module flash_ctrl_assertions
#(
  parameter SETTLE_CYCLES = 4
)
(
  input wire ref_clk_in,
  input wire reset_in,
  input wire [2:0] op_mode_in,
  input wire standby_in,
  input wire high_voltage_threshold_in,
  input wire [`ADDR_WIDTH-1:0] addr_in,
  input wire [7:0] wdata_in,
  input wire write_in,
  input wire read_in,
  input wire [7:0] rdata_out,
  input wire program_mode_out,
  input wire erase_mode_out,
  input wire program_verify_mode_out,
  input wire erase_verify_mode_out,
  input wire high_voltage_enable_out,
  input wire write_permit_out,
  input wire supply_settled_out,
  input wire block_selected_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  wire hv = high_voltage_threshold_in;
  wire on_ok = op_mode_in > 3'h4 && !standby_in && hv;
  wire rd0 = read_in && addr_in == `OFS_MODE_CONTROL;
  wire rd2 = read_in && addr_in == `OFS_LARGE_BLOCK_SEL;
  wire [4:0] modes = {high_voltage_enable_out, erase_verify_mode_out,
    program_verify_mode_out, erase_mode_out, program_mode_out};
  a_reserved_zero: assert property ($past(rd0) && rdata_out != 8'hFF
    |-> rdata_out[5:4] == 2'h0) else $error("reserved bits set");
  a_mode_write: assert property (on_ok [*6] ##0 write_in && !addr_in
    ##1 on_ok [*2] |-> modes == $past({wdata_in[6], wdata_in[3:0]}, 2)) else $error("bad modes");
  a_standby_clear: assert property (standby_in [*6] |-> modes == 5'h00)
    else $error("standby kept modes");
  a_novolt_clear: assert property (!hv [*6] |-> {modes, block_selected_out} == 6'h00)
    else $error("modes kept without supply");
  a_hw_protect: assert property ((op_mode_in > 3'h4 && $stable(hv)) [*6]
    |-> write_permit_out == hv) else $error("permit wrong");
  a_off_reads_ff: assert property (op_mode_in < 3'h5 [*6] ##0 (rd0 || rd2)
    |=> rdata_out == 8'hFF) else $error("disabled read wrong");
  a_detect_bit: assert property ((op_mode_in > 3'h4 && $stable(hv)) [*6] ##0 rd0
    |=> rdata_out[7] == $past(hv)) else $error("detect bit wrong");
  a_settle_wait: assert property ($rose(supply_settled_out)
    |-> $past(high_voltage_enable_out, 2)) else $error("settled early");
  cover property (on_ok [*6] ##0 write_in && wdata_in[0]);
  cover property (standby_in [*6]);
  cover property ($rose(supply_settled_out));
endmodule

bind flash_program_erase_control flash_ctrl_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.*);

// ### tb/tb_flash_program_erase_control.sv
// Purpose: Register test of the flash mode control block.
// Assumes: Pins hold 8 clocks before their effect is read.
// Notes: A settle count of 4 keeps the run short.
`timescale 1ns/1ns
`include "flash_ctrl_defs.vh"
module tb_flash_program_erase_control;
  reg ref_clk_in = 1'b0;
  reg reset_in = 1'b1;
  reg [2:0] op_mode_in = 3'h7;
  reg standby_in = 1'b0;
  reg high_voltage_threshold_in = 1'b1;
  reg [3:0] addr_in = 4'h0;
  reg [7:0] wdata_in = 8'h00;
  reg write_in = 1'b0;
  reg read_in = 1'b0;
  reg [16:0] flash_addr_in = 17'h00000;
  wire [7:0] rdata_out;
  wire program_mode_out, erase_mode_out, program_verify_mode_out, erase_verify_mode_out;
  wire high_voltage_enable_out, write_permit_out, supply_settled_out, block_selected_out;
  wire [7:0] modes = {3'h0, high_voltage_enable_out, erase_verify_mode_out,
    program_verify_mode_out, erase_mode_out, program_mode_out};
  wire [7:0] flags = {5'h00, write_permit_out, supply_settled_out, block_selected_out};
  integer err_total = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer i;
  always #25 ref_clk_in = ~ref_clk_in;
  flash_program_erase_control #(.SETTLE_CYCLES(4)) dut_u (.*);
  task check(input [7:0] got, input [7:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge ref_clk_in);
    write_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    write_in <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, input [7:0] exp);
  begin
    @(posedge ref_clk_in);
    read_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    read_in <= 1'b0;
    #1 check(rdata_out, exp);
  end
  endtask
  task print_verdict;
  begin
    $display("Comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // The ceiling is over ten times the expected run of about 290 clocks, so only a hang reaches it.
  always @(posedge ref_clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  initial
  begin
    idle(10);
    reset_in <= 1'b0;
    idle(2);
    rd(4'h0, 8'h80);
    rd(4'h2, 8'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(4'h0, 8'h40 | 8'h01 << i);
      idle(2);
      check(modes, 8'h10 | 8'h01 << i);
      rd(4'h0, 8'hC0 | 8'h01 << i);
    end
    wr(4'h0, 8'hF0);
    rd(4'h0, 8'hC0);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(4'h2, 8'h01 << i);
      rd(4'h2, 8'h01 << i);
      flash_addr_in <= 17'h04000 * i;
      idle(3);
      check(flags, 8'h07);
      flash_addr_in <= flash_addr_in ^ 17'h04000;
      idle(3);
      check(flags, 8'h06);
    end
    flash_addr_in <= 17'h1EFFF;
    idle(3);
    check(flags, 8'h07);
    flash_addr_in <= 17'h1F000;
    idle(3);
    check(flags, 8'h06);
    wr(4'h0, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'h00);
    wr(4'h0, 8'h41);
    wr(4'h2, 8'h0F);
    standby_in <= 1'b1;
    idle(8);
    standby_in <= 1'b0;
    idle(8);
    rd(4'h0, 8'h80);
    rd(4'h2, 8'h00);
    wr(4'h0, 8'h41);
    wr(4'h2, 8'h01);
    high_voltage_threshold_in <= 1'b0;
    idle(8);
    check(flags & 8'h04, 8'h00);
    wr(4'h0, 8'h41);
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h00);
    high_voltage_threshold_in <= 1'b1;
    idle(8);
    check(flags & 8'h04, 8'h04);
    for (i = 1; i < 8; i = i + 1)
    begin
      op_mode_in <= i[2:0];
      idle(8);
      wr(4'h0, 8'h44);
      rd(4'h0, i < 5 ? 8'hFF : 8'hC4);
      rd(4'h2, i < 5 ? 8'hFF : 8'h00);
    end
    print_verdict;
  end
endmodule
